// ==== inc/bmc_map.svh ====
`ifndef BMC_MAP_SVH
`define BMC_MAP_SVH

// Register byte offsets on the plain register port.
`define BMC_ADDR_W      12
`define BMC_MAILBOX_WORD_THREE_OFS   12'h70c
`define BMC_MISC_OFS    12'h800

// Control and status field positions.
`define BMC_SWRST_BIT   31
`define BMC_SBG_BIT     19
`define BMC_SBB_BIT     18
`define BMC_BOC_BIT     16
`define BMC_MABE_BIT    12
`define BMC_BLK8_BIT    9
`define BMC_FMODE_BIT   8
`define BMC_PRC_MSB     7
`define BMC_PRC_LSB     2
`define BMC_MODE_MSB    1
`define BMC_MODE_LSB    0

// Reset values.
`define BMC_MBOX_RST    32'h0000_0000
`define BMC_PRC_RST     6'h01
`define BMC_RD_ZERO     32'h0000_0000
`define BMC_ALL_ONES    32'hffff_ffff

// Grant synchroniser depth on the asynchronous path.
`define BMC_SYNC_DEPTH  2

`endif

// ==== inc/bmc_pkg.sv ====
package bmc_pkg;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bmc_reg_req_t;

  typedef struct packed {
    logic hit;
    logic is_write;
    logic delayed;
  } bmc_abort_req_t;

  typedef struct packed {
    logic        bus_error;
    logic        normal_end;
    logic        flush_write;
    logic [31:0] read_data;
  } bmc_abort_rsp_t;

  typedef enum logic [1:0] {
    BMC_MODE_A_LOW  = 2'b00,
    BMC_MODE_A_HIGH = 2'b01,
    BMC_MODE_B      = 2'b10,
    BMC_MODE_C      = 2'b11
  } bmc_mode_t;

endpackage

// ==== hdl/bmc_sync_sel.sv ====
`timescale 1ns/10ps
`include "bmc_map.svh"

module bmc_sync_sel #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic raw_in,
  input  wire logic sync_mode_in,
  output logic      sampled_out
);

  logic [`BMC_SYNC_DEPTH-1:0] chain;
  logic                       direct;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      chain <= {`BMC_SYNC_DEPTH{RESET_VAL}};
    end else begin
      chain <= {chain[`BMC_SYNC_DEPTH-2:0], raw_in};
    end
  end

  // A synchronous source is trusted and taken after two flops.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      direct <= RESET_VAL;
    end else begin
      direct <= raw_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sampled_out <= RESET_VAL;
    end else if (sync_mode_in) begin
      sampled_out <= direct;
    end else begin
      sampled_out <= chain[`BMC_SYNC_DEPTH-1];
    end
  end

endmodule // bmc_sync_sel

// ==== hdl/bmc_regs.sv ====
// Operation
// - Fourth mailbox, 32-bit read/write, reset zero.
// - Soft reset bit read/write, resets zero.
// - Grant sync select: 0 async, 1 sync.
// - Grant acknowledge sync select likewise.
// - Byte order select: 0 big, 1 little.
// - Delayed master-abort maps to bus error.
// - Disable bit set: normal end, flush, ones.
// - Prefetch bytes are four times count.
// - Soft reset drives, local and PCI clear.
// - Sync bits reset by latched master mode.
// - Mode field latched from straps at reset.
// - Register channel never byte swapped.
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`include "bmc_map.svh"

module bmc_regs (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire bmc_pkg::bmc_reg_req_t reg_req_in,
  output logic [31:0]                reg_rdata_out,
  input  wire logic                  local_reset_n_in,
  input  wire logic                  pci_reset_n_in,
  output logic                       local_reset_n_out,
  input  wire logic                  burst_in_progress_pin_in,
  input  wire logic                  size_bit_one_pin_in,
  input  wire logic                  bus_grant_n_in,
  input  wire logic                  grant_ack_n_in,
  output logic                       grant_synced_n_out,
  output logic                       grant_ack_synced_n_out,
  input  wire logic [31:0]           chan_data_in,
  input  wire logic                  chan_invert_in,
  output logic [31:0]                chan_data_out,
  input  wire bmc_pkg::bmc_abort_req_t abort_req_in,
  output bmc_pkg::bmc_abort_rsp_t    abort_rsp_out,
  output logic [7:0]                 prefetch_bytes_out,
  output logic                       byte_order_out
);

  //////////////////////////////////////////////////////////////////////////

  logic [31:0]        mailbox_payload;
  logic               local_soft_reset_bit;
  logic               pci_hold;
  logic               grant_sync_select;
  logic               grant_ack_sync_select;
  logic               local_byte_order_select;
  logic               abort_error_map_disable;
  logic               fifo_block_size_bit;
  logic               fifo_mode_bit;
  logic [5:0]         prefetch_count;
  bmc_pkg::bmc_mode_t master_slave_mode_field;
  logic               wr_mbox;
  logic               wr_misc;
  logic               rd_mbox;
  logic               rd_misc;
  logic               local_rst;
  logic               pci_rst;
  logic [31:0]        misc_word;
  logic [1:0]         sync_raw;
  logic [1:0]         sync_sel;
  logic [1:0]         sync_out;
  logic               swap_en;

  assign wr_mbox = reg_req_in.wr && (reg_req_in.addr == `BMC_MAILBOX_WORD_THREE_OFS);
  assign wr_misc = reg_req_in.wr && (reg_req_in.addr == `BMC_MISC_OFS);
  assign rd_mbox = reg_req_in.rd && (reg_req_in.addr == `BMC_MAILBOX_WORD_THREE_OFS);
  assign rd_misc = reg_req_in.rd && (reg_req_in.addr == `BMC_MISC_OFS);
  assign local_rst = !local_reset_n_in;
  assign pci_rst   = !pci_reset_n_in;

  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mailbox_payload <= `BMC_MBOX_RST;
    end else if (wr_mbox) begin
      mailbox_payload <= reg_req_in.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  // A hardware reset request beats a software write of one in the same
  // cycle: a reset that is still asserted must not be re-armed by software.
  // soft reset bit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      local_soft_reset_bit <= 1'b0;
    end else if (local_rst || pci_rst) begin
      local_soft_reset_bit <= 1'b0;
    end else if (wr_misc) begin
      local_soft_reset_bit <= reg_req_in.wdata[`BMC_SWRST_BIT];
    end
  end

  // The PCI reset keeps the output asserted until that reset negates.
  // hold through PCI reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pci_hold <= 1'b0;
    end else begin
      pci_hold <= pci_rst && (local_soft_reset_bit || pci_hold);
    end
  end

  // Combinational so that a cleared bit or a local reset negates at once.
  // Feeding this output back into the local reset input will oscillate.
  // reset output drive
  assign local_reset_n_out = !((local_soft_reset_bit && !local_rst)
                               || (pci_hold && pci_rst));

  //////////////////////////////////////////////////////////////////////////

  // Straps are sampled on every edge while reset is held, so the value at
  // the last reset edge is what software later reads.
  // strap latch
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      master_slave_mode_field <= bmc_pkg::bmc_mode_t'(
        {burst_in_progress_pin_in, size_bit_one_pin_in});
    end
  end

  // Modes with a low upper strap bit are the first processor type.
  // mode dependent reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      grant_sync_select <= burst_in_progress_pin_in;
    end else if (wr_misc) begin
      grant_sync_select <= reg_req_in.wdata[`BMC_SBG_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      grant_ack_sync_select <= burst_in_progress_pin_in;
    end else if (wr_misc) begin
      grant_ack_sync_select <= reg_req_in.wdata[`BMC_SBB_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      local_byte_order_select <= 1'b0;
    end else if (wr_misc) begin
      local_byte_order_select <= reg_req_in.wdata[`BMC_BOC_BIT];
    end
  end

  // A fresh bridge reports every master-abort as a bus error.
  // map disable reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      abort_error_map_disable <= 1'b0;
    end else if (wr_misc) begin
      abort_error_map_disable <= reg_req_in.wdata[`BMC_MABE_BIT];
    end
  end

  // These bits steer nothing here; they are kept so that a read shows
  // software a wrong setting instead of hiding it.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fifo_block_size_bit <= 1'b0;
      fifo_mode_bit       <= 1'b0;
    end else if (wr_misc) begin
      fifo_block_size_bit <= reg_req_in.wdata[`BMC_BLK8_BIT];
      fifo_mode_bit       <= reg_req_in.wdata[`BMC_FMODE_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prefetch_count <= `BMC_PRC_RST;
    end else if (wr_misc) begin
      prefetch_count <= reg_req_in.wdata[`BMC_PRC_MSB:`BMC_PRC_LSB];
    end
  end

  //////////////////////////////////////////////////////////////////////////

  always_comb begin
    misc_word                            = `BMC_RD_ZERO;
    misc_word[`BMC_SWRST_BIT]            = local_soft_reset_bit;
    misc_word[`BMC_SBG_BIT]              = grant_sync_select;
    misc_word[`BMC_SBB_BIT]              = grant_ack_sync_select;
    misc_word[`BMC_BOC_BIT]              = local_byte_order_select;
    misc_word[`BMC_MABE_BIT]             = abort_error_map_disable;
    misc_word[`BMC_BLK8_BIT]             = fifo_block_size_bit;
    misc_word[`BMC_FMODE_BIT]            = fifo_mode_bit;
    misc_word[`BMC_PRC_MSB:`BMC_PRC_LSB] = prefetch_count;
    misc_word[`BMC_MODE_MSB:`BMC_MODE_LSB] = master_slave_mode_field;
  end

  // Register reads bypass the swap network entirely.
  // register path unswapped
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= `BMC_RD_ZERO;
    end else if (rd_mbox) begin
      reg_rdata_out <= mailbox_payload;
    end else if (rd_misc) begin
      reg_rdata_out <= misc_word;
    end else begin
      reg_rdata_out <= `BMC_RD_ZERO;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  assign sync_raw = {grant_ack_n_in, bus_grant_n_in};
  assign sync_sel = {grant_ack_sync_select, grant_sync_select};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      bmc_sync_sel #(
        .RESET_VAL (1'b1)
      ) u_sync (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .raw_in       (sync_raw[i]),
        .sync_mode_in (sync_sel[i]),
        .sampled_out  (sync_out[i])
      );
    end
  endgenerate

  assign grant_synced_n_out     = sync_out[0];
  assign grant_ack_synced_n_out = sync_out[1];

  //////////////////////////////////////////////////////////////////////////

  // The channel inversion flag flips the select for as long as it is held high.
  // data channel ordering
  assign swap_en = !(local_byte_order_select ^ chan_invert_in);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      chan_data_out <= `BMC_RD_ZERO;
    end else if (swap_en) begin
      chan_data_out <= {chan_data_in[7:0], chan_data_in[15:8],
                        chan_data_in[23:16], chan_data_in[31:24]};
    end else begin
      chan_data_out <= chan_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      byte_order_out <= 1'b0;
    end else begin
      byte_order_out <= local_byte_order_select;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  // Only delayed transfers honour the disable bit; others always error.
  // abort as bus error
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      abort_rsp_out <= '0;
    end else begin
      abort_rsp_out <= '0;
      if (abort_req_in.hit) begin
        if (abort_req_in.delayed && abort_error_map_disable) begin
          abort_rsp_out.normal_end  <= 1'b1;
          abort_rsp_out.flush_write <= abort_req_in.is_write;
          if (!abort_req_in.is_write) begin
            abort_rsp_out.read_data <= `BMC_ALL_ONES;
          end
        end else begin
          abort_rsp_out.bus_error <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////

  // A count of zero prefetches nothing; the reset value asks for one word.
  // prefetch byte count
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prefetch_bytes_out <= 8'h00;
    end else begin
      prefetch_bytes_out <= {prefetch_count, 2'b00};
    end
  end

endmodule // bmc_regs

// ==== tb/bmc_regs_asserts.sv ====
`timescale 1ns/10ps
module bmc_regs_asserts (
  input wire logic                    clk_in,
  input wire logic                    rst_in,
  input wire bmc_pkg::bmc_reg_req_t   reg_req_in,
  input wire logic [31:0]             reg_rdata_out,
  input wire logic                    local_reset_n_in,
  input wire logic                    pci_reset_n_in,
  input wire logic                    local_reset_n_out,
  input wire logic                    bus_grant_n_in,
  input wire logic                    grant_ack_n_in,
  input wire logic                    grant_synced_n_out,
  input wire logic                    grant_ack_synced_n_out,
  input wire bmc_pkg::bmc_abort_req_t abort_req_in,
  input wire bmc_pkg::bmc_abort_rsp_t abort_rsp_out,
  input wire logic [7:0]              prefetch_bytes_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_hit_rd;
    abort_req_in.hit && !abort_req_in.is_write;
  endsequence
  sequence s_hit_wr;
    abort_req_in.hit && abort_req_in.is_write;
  endsequence
  sequence s_misc_rd;
    reg_req_in.rd && reg_req_in.addr == 12'h800;
  endsequence
  chk_abort_pulse: assert property (!abort_req_in.hit |=>
    !(abort_rsp_out.bus_error || abort_rsp_out.normal_end))
    else $error("abort response without a request");
  chk_error_map: assert property (abort_req_in.hit &&
    !abort_req_in.delayed |=> abort_rsp_out.bus_error)
    else $error("plain abort not reported as bus error");
  chk_read_ones: assert property (s_hit_rd |=>
    abort_rsp_out.normal_end == (abort_rsp_out.read_data == 32'hffff_ffff))
    else $error("normal end read data not all ones");
  chk_write_flush: assert property (s_hit_wr |=>
    abort_rsp_out.flush_write == abort_rsp_out.normal_end)
    else $error("write flush does not match normal end");
  chk_prefetch_x4: assert property (s_misc_rd |=>
    prefetch_bytes_out == {reg_rdata_out[7:2], 2'b00})
    else $error("prefetch bytes not four times count");
  chk_local_negate: assert property (!local_reset_n_in &&
    pci_reset_n_in |-> local_reset_n_out)
    else $error("local reset output held during local reset");
  chk_grant_sync: assert property ($stable(bus_grant_n_in)[*5] |->
    grant_synced_n_out == bus_grant_n_in)
    else $error("grant output does not follow input");
  chk_ack_sync: assert property ($stable(grant_ack_n_in)[*5] |->
    grant_ack_synced_n_out == grant_ack_n_in)
    else $error("grant acknowledge output does not follow");
  chk_rdata_idle: assert property (!reg_req_in.rd |=>
    reg_rdata_out == 32'h0000_0000)
    else $error("read data outside the read answer cycle");
endmodule // bmc_regs_asserts

// ==== tb/bmc_far.sv ====
`timescale 1ns/10ps
module bmc_far (
  input  wire logic               clk_in,
  output logic                    bus_grant_n_out,
  output logic                    grant_ack_n_out,
  output bmc_pkg::bmc_abort_req_t abort_req_out
);
  logic [4:0] cnt = 5'h00;
  // Uneven grant spans give both quick and slow changes on the pins.
  always @(posedge clk_in) cnt <= cnt + 5'h01;
  assign bus_grant_n_out = cnt[2] | cnt[4];
  assign grant_ack_n_out = cnt[3];
  initial abort_req_out = '0;
  task automatic abort(input logic wr, input logic dly);
    @(posedge clk_in);
    abort_req_out <= {1'b1, wr, dly};
    @(posedge clk_in);
    abort_req_out <= '0;
  endtask
endmodule // bmc_far

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
  logic                    clk_in = 1'b0;
  logic                    rst_in = 1'b1;
  logic                    lrst_n = 1'b1;
  logic                    prst_n = 1'b1;
  logic                    inv = 1'b0;
  logic                    burst_in_progress_pin = 1'b1, siz1 = 1'b0;
  logic [2:0]              g_hist = 3'h0, a_hist = 3'h0;
  logic                    lrst_out_n, g_n, ga_n, gs_n, gas_n, order;
  logic [31:0]             rdata, cdo;
  logic [7:0]              pf;
  bmc_pkg::bmc_reg_req_t   req = '0;
  bmc_pkg::bmc_abort_req_t ab;
  bmc_pkg::bmc_abort_rsp_t rsp;
  int                      miscompares = 0, checks_done = 0, cycles = 0;
  bmc_regs i_bmc_regs (.clk_in, .rst_in, .reg_req_in(req),
    .reg_rdata_out(rdata), .local_reset_n_in(lrst_n),
    .pci_reset_n_in(prst_n), .local_reset_n_out(lrst_out_n),
    .burst_in_progress_pin_in(burst_in_progress_pin), .size_bit_one_pin_in(siz1),
    .bus_grant_n_in(g_n), .grant_ack_n_in(ga_n),
    .grant_synced_n_out(gs_n), .grant_ack_synced_n_out(gas_n),
    .chan_data_in(32'h1122_3344), .chan_invert_in(inv),
    .chan_data_out(cdo), .abort_req_in(ab), .abort_rsp_out(rsp),
    .prefetch_bytes_out(pf), .byte_order_out(order));
  bmc_far i_far (.clk_in, .bus_grant_n_out(g_n), .grant_ack_n_out(ga_n),
    .abort_req_out(ab));
  initial forever #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(input string n, input logic [35:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req <= {a, d, 2'b10};
    @(posedge clk_in);
    req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    req <= {a, 32'h0, 2'b01};
    @(posedge clk_in);
    req <= '0;
    #1 check("read data", rdata, exp);
  endtask
  task automatic chan(input logic i, input logic [31:0] exp);
    @(posedge clk_in);
    inv <= i;
    @(posedge clk_in);
    #1 check("channel", cdo, exp);
  endtask
  // Pin history lets the bench predict each synchroniser latency.
  always @(posedge clk_in) begin
    g_hist <= {g_hist[1:0], g_n};
    a_hist <= {a_hist[1:0], ga_n};
  end
  task automatic grant_lat(input int d);
    repeat (16) begin
      @(posedge clk_in);
      #1 check("grant sync", gs_n, g_hist[d]);
      check("grant ack sync", gas_n, a_hist[d]);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(12'h800, 32'h000c_0006);
    check("prefetch", pf, 36'h4);
    grant_lat(1);
    rd(12'h70c, 32'h0);
    wr(12'h70c, 32'ha5c3_0f96);
    rd(12'h70c, 32'ha5c3_0f96);
    // Map disable goes first and both fifo bits are kept clear.
    wr(12'h800, 32'hffff_fcff);
    #1 check("soft reset out", lrst_out_n, 36'h0);
    rd(12'h800, 32'h800d_10fe);
    check("prefetch", pf, 36'hfc);
    check("order", order, 36'h1);
    chan(1'b0, 32'h1122_3344);
    chan(1'b1, 32'h4433_2211);
    rd(12'h70c, 32'ha5c3_0f96);
    i_far.abort(1'b0, 1'b1);
    #1 check("abort read", rsp, {3'b010, 32'hffff_ffff});
    i_far.abort(1'b1, 1'b1);
    #1 check("abort write", rsp, {3'b011, 32'h0});
    i_far.abort(1'b0, 1'b0);
    #1 check("plain abort", rsp, {3'b100, 32'h0});
    @(posedge clk_in) lrst_n <= 1'b0;
    #1 check("local reset", lrst_out_n, 36'h1);
    @(posedge clk_in) lrst_n <= 1'b1;
    #1 check("local reset", lrst_out_n, 36'h1);
    rd(12'h800, 32'h000d_10fe);
    wr(12'h800, 32'h8000_0000);
    @(posedge clk_in) prst_n <= 1'b0;
    @(posedge clk_in);
    #1 check("pci hold", lrst_out_n, 36'h0);
    rd(12'h800, 32'h0000_0002);
    @(posedge clk_in) prst_n <= 1'b1;
    #1 check("pci release", lrst_out_n, 36'h1);
    chan(1'b0, 32'h4433_2211);
    i_far.abort(1'b0, 1'b1);
    #1 check("mapped abort", rsp, {3'b100, 32'h0});
    wr(12'h800, 32'h0000_0030);
    rd(12'h800, 32'h0000_0032);
    check("prefetch", pf, 36'h30);
    wr(12'h804, 32'hffff_ffff);
    rd(12'h804, 32'h0);
    rd(12'h800, 32'h0000_0032);
    // The second reset latches the other strap mode, then the straps move.
    @(posedge clk_in) rst_in <= 1'b1;
    burst_in_progress_pin <= 1'b0;
    siz1 <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    burst_in_progress_pin <= 1'b1;
    siz1 <= 1'b0;
    rd(12'h70c, 32'h0);
    rd(12'h800, 32'h0000_0005);
    grant_lat(2);
    finish_test();
  end
endmodule // tb
bind bmc_regs bmc_regs_asserts i_chk (.clk_in, .rst_in, .reg_req_in,
  .reg_rdata_out, .local_reset_n_in, .pci_reset_n_in, .local_reset_n_out,
  .bus_grant_n_in, .grant_ack_n_in, .grant_synced_n_out,
  .grant_ack_synced_n_out, .abort_req_in, .abort_rsp_out,
  .prefetch_bytes_out);
